// ### pkg/gsr_pkg.sv
package gsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry of the register file.
  localparam int unsigned NUM_REGS     = 16;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned REG_W        = 64;
  localparam int unsigned HALF_W       = 32;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned HIGH_LSB     = 8;
  localparam logic [REG_W-1:0]  GPR_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [HALF_W-1:0] UPPER_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Operand size codes as presented by decode.
  typedef enum logic [1:0] {
    GSR_BYTE  = 2'h0,
    GSR_WORD  = 2'h1,
    GSR_DWORD = 2'h3,
    GSR_QWORD = 2'h2
  } gsr_size_type;

  // All state of the register file in one vector.
  typedef struct packed {
    logic [NUM_REGS-1:0][REG_W-1:0] gpr;
    logic [REG_W-1:0]               rdData;
    logic                           rdValid;
    logic                           fault;
    logic                           mode64Prev;
  } gsr_state_type;

endpackage : gsr_pkg

// ### src/gsr_register_file.sv
module gsr_register_file (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  // Mode and per-instruction extension prefix
  input  wire logic                          mode64,
  input  wire logic                          register_extension_prefix,
  // Write port from execute
  input  wire logic                          wrEn,
  input  wire logic [gsr_pkg::IDX_W-1:0]     wrIdx,
  input  wire gsr_pkg::gsr_size_type         wrSize,
  input  wire logic [gsr_pkg::REG_W-1:0]     wrData,
  // Read port from decode
  input  wire logic                          rdEn,
  input  wire logic [gsr_pkg::IDX_W-1:0]     rdIdx,
  input  wire gsr_pkg::gsr_size_type         rdSize,
  // Answers
  output logic      [gsr_pkg::REG_W-1:0]     rdData,
  output logic                               rdValid,
  output logic                               fault
);

  ////////////////////////////////////////////////////////////////////////////
  // Operand decode helpers.

  // Physical register that a view names; without the prefix only three index bits exist.
  function automatic logic [gsr_pkg::IDX_W-1:0] regNum(input logic [gsr_pkg::IDX_W-1:0] idx,
                                                      input gsr_pkg::gsr_size_type sz,
                                                      input logic pfx);
    regNum = idx;
    if (!pfx) begin
      regNum = {1'h0, idx[2:0]};
      if (sz == gsr_pkg::GSR_BYTE && idx[2]) begin
        regNum = {2'h0, idx[1:0]};
      end
    end
  endfunction : regNum

  // High-byte view only for codes 4..7 without prefix; the prefix turns them into low bytes.
  function automatic logic highSel(input logic [gsr_pkg::IDX_W-1:0] idx,
                                   input gsr_pkg::gsr_size_type sz,
                                   input logic pfx);
    highSel = (sz == gsr_pkg::GSR_BYTE) && !pfx && idx[2];
  endfunction : highSel

  // Quadword view is not selectable without the prefix.
  function automatic logic illegalView(input gsr_pkg::gsr_size_type sz, input logic pfx);
    illegalView = (sz == gsr_pkg::GSR_QWORD) && !pfx;
  endfunction : illegalView

  // Extract a zero-extended view of a register.
  function automatic logic [gsr_pkg::REG_W-1:0] viewOf(input logic [gsr_pkg::REG_W-1:0] r,
                                                      input gsr_pkg::gsr_size_type sz,
                                                      input logic hi);
    viewOf = '0;
    unique case (sz)
      gsr_pkg::GSR_BYTE:  viewOf[gsr_pkg::BYTE_W-1:0] = hi ? r[gsr_pkg::WORD_W-1:gsr_pkg::HIGH_LSB]
                                                           : r[gsr_pkg::BYTE_W-1:0];
      gsr_pkg::GSR_WORD:  viewOf[gsr_pkg::WORD_W-1:0] = r[gsr_pkg::WORD_W-1:0];
      gsr_pkg::GSR_DWORD: viewOf[gsr_pkg::HALF_W-1:0] = r[gsr_pkg::HALF_W-1:0];
      gsr_pkg::GSR_QWORD: viewOf = r;
    endcase
  endfunction : viewOf

  // Merge a result into the old register value according to operand size.
  function automatic logic [gsr_pkg::REG_W-1:0] mergeWrite(input logic [gsr_pkg::REG_W-1:0] old,
                                                          input logic [gsr_pkg::REG_W-1:0] d,
                                                          input gsr_pkg::gsr_size_type sz,
                                                          input logic hi);
    mergeWrite = old;
    unique case (sz)
      gsr_pkg::GSR_BYTE: begin
        if (hi) begin
          mergeWrite[gsr_pkg::WORD_W-1:gsr_pkg::HIGH_LSB] = d[gsr_pkg::BYTE_W-1:0];
        end else begin
          mergeWrite[gsr_pkg::BYTE_W-1:0] = d[gsr_pkg::BYTE_W-1:0];
        end
      end
      gsr_pkg::GSR_WORD:  mergeWrite[gsr_pkg::WORD_W-1:0] = d[gsr_pkg::WORD_W-1:0];
      gsr_pkg::GSR_DWORD: mergeWrite = {gsr_pkg::UPPER_ZERO, d[gsr_pkg::HALF_W-1:0]};
      gsr_pkg::GSR_QWORD: mergeWrite = d;
    endcase
  endfunction : mergeWrite

  ////////////////////////////////////////////////////////////////////////////
  // State and next-state logic.

  gsr_pkg::gsr_state_type stateReg;
  gsr_pkg::gsr_state_type stateNext;
  logic [gsr_pkg::IDX_W-1:0] wrNum;
  logic                      wrHigh;
  logic                      wrBad;
  logic [gsr_pkg::IDX_W-1:0] rdNum;
  logic                      rdHigh;
  logic                      rdBad;
  logic                      modeExit;

  // One prefix input serves every operand of the instruction, so high and new bytes cannot mix.
  assign wrNum    = regNum(wrIdx, wrSize, register_extension_prefix);
  assign wrHigh   = highSel(wrIdx, wrSize, register_extension_prefix);
  assign wrBad    = illegalView(wrSize, register_extension_prefix);
  assign rdNum    = regNum(rdIdx, rdSize, register_extension_prefix);
  assign rdHigh   = highSel(rdIdx, rdSize, register_extension_prefix);
  assign rdBad    = illegalView(rdSize, register_extension_prefix);
  assign modeExit = stateReg.mode64Prev && !mode64;

  // Read returns the pre-write value when the same register is written in the same cycle.
  always_comb begin
    stateNext            = stateReg;
    stateNext.mode64Prev = mode64;
    stateNext.rdValid    = rdEn && !rdBad;
    stateNext.fault      = (rdEn && rdBad) || (wrEn && wrBad);
    if (rdEn && !rdBad) begin
      stateNext.rdData = viewOf(stateReg.gpr[rdNum], rdSize, rdHigh);
    end
    if (wrEn && !wrBad) begin
      stateNext.gpr[wrNum] = mergeWrite(stateReg.gpr[wrNum], wrData, wrSize, wrHigh);
    end
    // Upper halves are zeroed on leaving 64-bit mode; cheaper to test than truly undefined bits.
    if (modeExit) begin
      for (int i = 0; i < gsr_pkg::NUM_REGS; i++) begin
        stateNext.gpr[i][gsr_pkg::REG_W-1:gsr_pkg::HALF_W] = gsr_pkg::UPPER_ZERO;
      end
    end
  end

  // Single register stage for all state; the mode history resets low, so that
  // holding mode64 low across the release of reset is never taken for an exit.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stateReg <= '{gpr: {gsr_pkg::NUM_REGS{gsr_pkg::GPR_RESET}}, rdData: gsr_pkg::GPR_RESET,
                    rdValid: 1'h0, fault: 1'h0, mode64Prev: 1'h0};
    end else begin
      stateReg <= stateNext;
    end
  end

  assign rdData  = stateReg.rdData;
  assign rdValid = stateReg.rdValid;
  assign fault   = stateReg.fault;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register file.

  sequence s_steady64;
    mode64 && stateReg.mode64Prev;
  endsequence

  // A mode exit in the same cycle overrides the upper half of any write, so write checks need a steady mode.
  sequence s_write(gsr_pkg::gsr_size_type sz);
    (wrEn && wrSize == sz && !wrBad) and s_steady64;
  endsequence

  a_qword_full_write: assert property (@(posedge clk_sys) disable iff (reset)
    s_write(gsr_pkg::GSR_QWORD) ##0 mode64 |=> stateReg.gpr[$past(wrNum)] == $past(wrData))
    else $error("quadword write did not replace the register");

  a_dword_zero_ext: assert property (@(posedge clk_sys) disable iff (reset)
    s_write(gsr_pkg::GSR_DWORD) |=>
      stateReg.gpr[$past(wrNum)] == {gsr_pkg::UPPER_ZERO, $past(wrData[gsr_pkg::HALF_W-1:0])})
    else $error("doubleword write was not zero extended");

  a_word_keeps_upper: assert property (@(posedge clk_sys) disable iff (reset)
    s_write(gsr_pkg::GSR_WORD) |=>
      stateReg.gpr[$past(wrNum)][gsr_pkg::REG_W-1:gsr_pkg::WORD_W] ==
      $past(stateReg.gpr[wrNum][gsr_pkg::REG_W-1:gsr_pkg::WORD_W]))
    else $error("word write disturbed upper bits");

  a_byte_keeps_rest: assert property (@(posedge clk_sys) disable iff (reset)
    s_write(gsr_pkg::GSR_BYTE) ##0 !wrHigh |=>
      stateReg.gpr[$past(wrNum)][gsr_pkg::REG_W-1:gsr_pkg::BYTE_W] ==
      $past(stateReg.gpr[wrNum][gsr_pkg::REG_W-1:gsr_pkg::BYTE_W]))
    else $error("low byte write disturbed other bits");

  a_quad_refused: assert property (@(posedge clk_sys) disable iff (reset)
    (rdEn || wrEn) && !register_extension_prefix && (rdSize == gsr_pkg::GSR_QWORD || wrSize == gsr_pkg::GSR_QWORD)
      && ((rdEn && rdSize == gsr_pkg::GSR_QWORD) || (wrEn && wrSize == gsr_pkg::GSR_QWORD)) |=> fault)
    else $error("quadword view without prefix not refused");

  a_high_byte_map: assert property (@(posedge clk_sys) disable iff (reset)
    wrEn && wrSize == gsr_pkg::GSR_BYTE && !register_extension_prefix && wrIdx[2]
      |-> wrHigh && wrNum == {2'h0, wrIdx[1:0]})
    else $error("high byte code mapped wrongly");

  a_prefix_remap: assert property (@(posedge clk_sys) disable iff (reset)
    rdEn && rdSize == gsr_pkg::GSR_BYTE && register_extension_prefix
      |=> rdValid && $past(rdNum) == $past(rdIdx)
          && rdData == {56'h0, $past(stateReg.gpr[rdNum][gsr_pkg::BYTE_W-1:0])})
    else $error("prefixed byte read not taken from low byte");

  // Read answers: data of an absent or refused read must stay as it was.
  a_read_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    rdEn && !rdBad |=> rdValid)
    else $error("accepted read gave no valid pulse");

  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !(rdEn && !rdBad) |=> $stable(rdData) && !rdValid)
    else $error("read data moved without an accepted read");

  a_fault_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !(rdEn && rdBad) && !(wrEn && wrBad) |=> !fault)
    else $error("fault raised without a refused view");

  a_low_byte_map: assert property (@(posedge clk_sys) disable iff (reset)
    rdEn && rdSize == gsr_pkg::GSR_BYTE && !register_extension_prefix && !rdIdx[2]
      |=> rdData == {56'h0, $past(stateReg.gpr[rdIdx[1:0]][gsr_pkg::BYTE_W-1:0])})
    else $error("low byte read taken from the wrong place");

  a_high_byte_read: assert property (@(posedge clk_sys) disable iff (reset)
    rdEn && rdSize == gsr_pkg::GSR_BYTE && !register_extension_prefix && rdIdx[2]
      |=> rdData == {56'h0, $past(stateReg.gpr[rdIdx[1:0]][gsr_pkg::WORD_W-1:gsr_pkg::HIGH_LSB])})
    else $error("high byte read not taken from bits 15:8");

  a_legacy_word_read: assert property (@(posedge clk_sys) disable iff (reset)
    rdEn && rdSize == gsr_pkg::GSR_WORD && !register_extension_prefix
      |=> rdData == {48'h0, $past(stateReg.gpr[rdIdx[2:0]][gsr_pkg::WORD_W-1:0])})
    else $error("unprefixed word read from the wrong register");

  a_legacy_dword_idx: assert property (@(posedge clk_sys) disable iff (reset)
    rdEn && rdSize == gsr_pkg::GSR_DWORD && !register_extension_prefix |-> !rdNum[gsr_pkg::IDX_W-1])
    else $error("unprefixed dword reached an extended register");

  a_mode_exit_clear: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(mode64) |=> stateReg.gpr[0][gsr_pkg::REG_W-1:gsr_pkg::HALF_W] == gsr_pkg::UPPER_ZERO
      && stateReg.gpr[15][gsr_pkg::REG_W-1:gsr_pkg::HALF_W] == gsr_pkg::UPPER_ZERO)
    else $error("upper halves survived leaving 64-bit mode");

endmodule : gsr_register_file

// ### tb/gsr_pipe_model.sv
module gsr_pipe_model (
  // Clock
  input  wire logic             clk_sys,
  // Requests towards the register file
  output logic                  mode64,
  output logic                  register_extension_prefix,
  output logic                  wrEn,
  output logic [3:0]            wrIdx,
  output gsr_pkg::gsr_size_type wrSize,
  output logic [63:0]           wrData,
  output logic                  rdEn,
  output logic [3:0]            rdIdx,
  output gsr_pkg::gsr_size_type rdSize
);
  timeunit 1ns;
  timeprecision 1ns;

  // The pipeline starts idle in 64-bit mode.
  initial begin
    mode64 = 1'b1;
    register_extension_prefix = 1'b0;
    {wrEn, rdEn, wrIdx, rdIdx, wrData} = '0;
    wrSize = gsr_pkg::GSR_BYTE;
    rdSize = gsr_pkg::GSR_BYTE;
  end

  // One instruction for one cycle; its single prefix qualifies every operand.
  task automatic op(input logic we, input logic re, input logic pfx, input logic [3:0] idx,
                    input gsr_pkg::gsr_size_type sz, input logic [63:0] d);
    @(posedge clk_sys);
    register_extension_prefix <= pfx;
    {wrEn, rdEn} <= {we, re};
    {wrIdx, rdIdx} <= {idx, idx};
    wrSize <= sz;
    rdSize <= sz;
    wrData <= d;
    @(posedge clk_sys);
    {wrEn, rdEn} <= 2'h0;
    wrData <= ~d; // Released data must not keep showing the last result.
  endtask : op

  // Mode changes are launched on a clock edge like any other request.
  task automatic set_mode(input logic m);
    @(posedge clk_sys);
    mode64 <= m;
  endtask : set_mode
endmodule : gsr_pipe_model

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk_sys = 1'b0;
  logic                  reset = 1'b1;
  logic                  mode64, register_extension_prefix, wrEn, rdEn, rdValid, fault;
  logic [3:0]            wrIdx, rdIdx;
  gsr_pkg::gsr_size_type wrSize, rdSize;
  logic [63:0]           wrData, rdData;
  logic [63:0]           model [16] = '{default: 64'h0};
  logic [63:0]           lastRd = 64'h0;
  int                    mismatches = 0;
  int                    comparisons = 0;
  int                    cycles = 0;

  always #50 clk_sys = ~clk_sys;
  gsr_pipe_model i_pipe (.clk_sys, .mode64, .register_extension_prefix, .wrEn, .wrIdx, .wrSize, .wrData,
                         .rdEn, .rdIdx, .rdSize);
  gsr_register_file i_dut (.clk_sys, .reset, .mode64, .register_extension_prefix, .wrEn, .wrIdx, .wrSize,
                           .wrData, .rdEn, .rdIdx, .rdSize, .rdData, .rdValid, .fault);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling: the whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One access through the pipeline model, judged against the reference copy.
  task automatic acc(input logic we, input logic re, input logic pfx, input logic [3:0] idx,
                     input gsr_pkg::gsr_size_type sz, input logic [63:0] d);
    logic [3:0]  r;
    logic        hi;
    logic        bad;
    logic [63:0] v;
    r = pfx ? idx : ((sz == gsr_pkg::GSR_BYTE) ? {2'h0, idx[1:0]} : {1'h0, idx[2:0]});
    hi = !pfx && sz == gsr_pkg::GSR_BYTE && idx[2];
    bad = !pfx && sz == gsr_pkg::GSR_QWORD;
    case (sz)
      gsr_pkg::GSR_BYTE:  v = {56'h0, hi ? model[r][15:8] : model[r][7:0]};
      gsr_pkg::GSR_WORD:  v = {48'h0, model[r][15:0]};
      gsr_pkg::GSR_DWORD: v = {32'h0, model[r][31:0]};
      default:            v = model[r];
    endcase
    i_pipe.op(we, re, pfx, idx, sz, d);
    #1;
    chk("fault", {63'h0, bad & (we | re)}, {63'h0, fault});
    chk("rdValid", {63'h0, re & !bad}, {63'h0, rdValid});
    chk("rdData", (re && !bad) ? v : lastRd, rdData);
    if (re && !bad) lastRd = v;
    if (we && !bad) begin
      case (sz)
        gsr_pkg::GSR_BYTE:  if (hi) model[r][15:8] = d[7:0]; else model[r][7:0] = d[7:0];
        gsr_pkg::GSR_WORD:  model[r][15:0] = d[15:0];
        gsr_pkg::GSR_DWORD: model[r] = {32'h0, d[31:0]};
        default:            model[r] = d;
      endcase
    end
  endtask : acc

  task automatic dump;
    for (int i = 0; i < 16; i++) acc(1'h0, 1'h1, 1'h1, 4'(i), gsr_pkg::GSR_QWORD, 64'h0);
  endtask : dump

  ////////////////////////////////////////////////////////////////////////////
  // Every view of every register with the prefix, and of codes 0 to 7 without it.
  task automatic t_views;
    for (int i = 0; i < 16; i++) begin
      acc(1'h1, 1'h0, 1'h1, 4'(i), gsr_pkg::GSR_QWORD, 64'hFEDC_BA98_7654_3210 ^ {16{4'(i)}});
    end
    for (int i = 0; i < 16; i++) begin
      for (int s = 0; s < 4; s++) begin
        acc(1'h0, 1'h1, 1'h1, 4'(i), gsr_pkg::gsr_size_type'(2'(s)), 64'h0);
        if (i < 8) begin
          acc(1'h0, 1'h1, 1'h0, 4'(i), gsr_pkg::gsr_size_type'(2'(s)), 64'h0);
        end
      end
    end
  endtask : t_views

  // Write widths: kept, zeroed and replaced upper bits, plus a refused write.
  task automatic t_widths;
    acc(1'b1, 1'b1, 1'b0, 4'h4, gsr_pkg::GSR_BYTE, 64'h1111_2222_3333_44AB);
    acc(1'b1, 1'b0, 1'b1, 4'h5, gsr_pkg::GSR_BYTE, 64'h0000_0000_0000_005C);
    acc(1'b1, 1'b0, 1'b1, 4'h9, gsr_pkg::GSR_WORD, 64'h0000_0000_0000_BEEF);
    acc(1'b1, 1'b0, 1'b0, 4'hB, gsr_pkg::GSR_DWORD, 64'hFFFF_FFFF_1234_5678);
    acc(1'b1, 1'b0, 1'b1, 4'hC, gsr_pkg::GSR_QWORD, 64'h0123_4567_89AB_CDEF);
    acc(1'h1, 1'h1, 1'h0, 4'h1, gsr_pkg::GSR_BYTE, 64'hAAAA_AAAA_AAAA_AA3C);
    acc(1'h1, 1'h0, 1'h0, 4'hE, gsr_pkg::GSR_WORD, 64'h5555_5555_5555_7E81);
    acc(1'h1, 1'h1, 1'h1, 4'hD, gsr_pkg::GSR_DWORD, 64'h9999_9999_0F0F_F0F0);
    acc(1'b1, 1'b0, 1'b0, 4'h2, gsr_pkg::GSR_QWORD, 64'hFFFF_FFFF_FFFF_FFFF);
    dump();
  endtask : t_widths

  // Leaving 64-bit mode; this design reads the lost upper halves as zero.
  task automatic t_mode;
    i_pipe.set_mode(1'h0);
    for (int i = 0; i < 16; i++) model[i][63:32] = 32'h0;
    dump();
    i_pipe.set_mode(1'b1);
  endtask : t_mode

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_views();
    t_widths();
    t_mode();
    end_sim();
  end
endmodule : tb
